// ==== pkg/timer_regs.svh ====
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register indices; byte address is four times the index
`define CTRL_FLAGS_IDX 10'h088
`define MODE_SEL_IDX 10'h089
`define LOW0_IDX 10'h08a
`define LOW1_IDX 10'h08b
`define HIGH0_IDX 10'h08c
`define HIGH1_IDX 10'h08d
`define IRQ_STATUS_IDX 10'h090
`define IRQ_MASK_IDX 10'h091

// Control/flag register fields
`define OVF1_BIT 7
`define RUN1_BIT 6
`define OVF0_BIT 5
`define RUN0_BIT 4
`define PIN1F_BIT 3
`define PIN0F_BIT 1

// Mode register fields
`define GATE_EN1_BIT 7
`define SRC1_BIT 6
`define MODE1_HI 5
`define MODE1_LO 4
`define GATE_EN0_BIT 3
`define SRC0_BIT 2
`define MODE0_HI 1
`define MODE0_LO 0

// Interrupt status bit positions
`define EV_OVF0 0
`define EV_OVF1 1
`define EV_PIN0 2
`define EV_PIN1 3

// Reset values
`define CTRL_FLAGS_RST 8'h00
`define MODE_SEL_RST 8'h00
`define COUNT_RST 8'h00
`define IRQ_MASK_RST 4'h0

// Core clocks per internal timer tick
`define TICK_DIV 12

`endif

// ==== pkg/timer_pkg.sv ====
package timer_pkg;

    // Order matches the two mode bits 00..11
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD,
        MODE_SPLIT
    } mode_e;

    typedef logic [1:0] axi_resp_t;

endpackage : timer_pkg

// ==== core/tick_divider.sv ====
`timescale 1ns/1ps
`include "timer_regs.svh"

module tick_divider #(
    parameter int DIV = `TICK_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // One-cycle enable every DIV clocks
    output logic tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else if (cnt == CW'(DIV - 1)) begin
            cnt <= '0;
            tick <= 1'b1;
        end else begin
            cnt <= cnt + CW'(1);
            tick <= 1'b0;
        end
    end

endmodule : tick_divider

// ==== core/pin_sync.sv ====
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pin,
    // Synchronised level and falling-edge pulse
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // Idle-high reset avoids a false edge after release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '1;
            level <= '1;
            prev <= '1;
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
        end
    end

    assign fall = prev & ~level;

endmodule : pin_sync

// ==== core/dual_timer_counter.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer_regs.svh"

// Contract
// (R1) Timer mode advances the count once every 12 core clocks while enabled.
// (R2) Counter mode advances on each falling edge of the timer's count pin.
// (R3) Count pins are sampled every core clock; edges come from those samples.
// (R4) Control/flag register resets to zero with the listed bit layout.
// (R5) Software cannot write overflow flags; interrupt entry clears them.
// (R6) Timer counts only while its run bit is set; clearing holds the count.
// (R7) Pin interrupt flags are software read/write and cleared on interrupt entry.
// (R8) With gate enabled, the gate pin must also be high for counting.
// (R9) Source select set uses the count pin, cleared uses divided core clock.
// (R10) Mode register layout: gate, source, two mode bits per timer, all RW.
// (R11) Mode 00: low byte is 5-bit prescaler into high byte, 13 bits total.
// (R12) Mode 01: low and high bytes cascade into one 16-bit counter.
// (R13) Each count is two separately addressable 8-bit byte registers.
// (R14) Mode 2: low byte counts, reloads from high byte on overflow.
// (R15) Mode 3 on timer 0 only: two 8-bit counters sharing timer 1 control.
// (R16) Overflow of the active width sets that timer's overflow flag.
// (R17) Mode 10 selects auto-reload, mode 11 selects split.
module dual_timer_counter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // External pins, asynchronous
    input wire logic timer_zero_count_pin,
    input wire logic timer_one_count_pin,
    input wire logic gate_zero_pin,
    input wire logic gate_one_pin,
    // Interrupt entry strobes from the processor
    input wire logic isr_enter_timer_zero,
    input wire logic isr_enter_timer_one,
    input wire logic isr_enter_pin_zero,
    input wire logic isr_enter_pin_one,
    // Interrupt
    output logic irq
);
    localparam timer_pkg::axi_resp_t RESP_OKAY = 2'h0;
    localparam timer_pkg::axi_resp_t RESP_SLVERR = 2'h2;

    function automatic logic is_reg(input logic [11:0] a, input logic [9:0] idx);
        return a[11:2] == idx && a[1:0] == 2'h0;
    endfunction : is_reg

    function automatic logic is_mapped(input logic [11:0] a);
        return is_reg(a, `CTRL_FLAGS_IDX) || is_reg(a, `MODE_SEL_IDX) ||
               is_reg(a, `LOW0_IDX) || is_reg(a, `LOW1_IDX) ||
               is_reg(a, `HIGH0_IDX) || is_reg(a, `HIGH1_IDX) ||
               is_reg(a, `IRQ_STATUS_IDX) || is_reg(a, `IRQ_MASK_IDX);
    endfunction : is_mapped

    // One count step: returns {overflow, high, low}
    function automatic logic [16:0] step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (timer_pkg::mode_e'(mode))
            timer_pkg::MODE_13BIT: begin
                if (lo[4:0] == 5'h1f) begin // R11
                    r = {hi == 8'hff, hi + 8'h01, lo[7:5], 5'h00};
                end else begin
                    r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                end
            end
            timer_pkg::MODE_16BIT: begin
                r = {1'b0, hi, lo} + 17'h00001; // R12
            end
            timer_pkg::MODE_RELOAD: begin
                if (lo == 8'hff) begin // R14
                    r = {1'b1, hi, hi};
                end else begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            default: begin
                r = {lo == 8'hff, hi, lo + 8'h01}; // R15
            end
        endcase
        return r;
    endfunction : step

    // Registers
    logic [7:0] timer_ctrl_flags;
    logic [7:0] timer_mode_select;
    logic [7:0] timer_zero_low_byte;
    logic [7:0] timer_one_low_byte;
    logic [7:0] timer_zero_high_byte;
    logic [7:0] timer_one_high_byte;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;

    // Write channel state
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic wr_fire;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Byte-lane 0 only; upper lanes read as zero
    logic wr_ctrl;
    logic wr_mode;
    logic wr_t0l;
    logic wr_t1l;
    logic wr_t0h;
    logic wr_t1h;
    logic wr_stat;
    logic wr_mask;

    assign wr_ctrl = wr_fire && w_lane && is_reg(aw_addr, `CTRL_FLAGS_IDX);
    assign wr_mode = wr_fire && w_lane && is_reg(aw_addr, `MODE_SEL_IDX);
    assign wr_t0l = wr_fire && w_lane && is_reg(aw_addr, `LOW0_IDX);
    assign wr_t1l = wr_fire && w_lane && is_reg(aw_addr, `LOW1_IDX);
    assign wr_t0h = wr_fire && w_lane && is_reg(aw_addr, `HIGH0_IDX);
    assign wr_t1h = wr_fire && w_lane && is_reg(aw_addr, `HIGH1_IDX);
    assign wr_stat = wr_fire && w_lane && is_reg(aw_addr, `IRQ_STATUS_IDX);
    assign wr_mask = wr_fire && w_lane && is_reg(aw_addr, `IRQ_MASK_IDX);

    // Read channel
    logic [7:0] rd_mux;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_mux = 8'h00;
        if (is_reg(s_axi_araddr, `CTRL_FLAGS_IDX)) begin
            rd_mux = timer_ctrl_flags;
        end else if (is_reg(s_axi_araddr, `MODE_SEL_IDX)) begin
            rd_mux = timer_mode_select;
        end else if (is_reg(s_axi_araddr, `LOW0_IDX)) begin
            rd_mux = timer_zero_low_byte;
        end else if (is_reg(s_axi_araddr, `LOW1_IDX)) begin
            rd_mux = timer_one_low_byte;
        end else if (is_reg(s_axi_araddr, `HIGH0_IDX)) begin
            rd_mux = timer_zero_high_byte;
        end else if (is_reg(s_axi_araddr, `HIGH1_IDX)) begin
            rd_mux = timer_one_high_byte;
        end else if (is_reg(s_axi_araddr, `IRQ_STATUS_IDX)) begin
            rd_mux = {4'h0, irq_status};
        end else if (is_reg(s_axi_araddr, `IRQ_MASK_IDX)) begin
            rd_mux = {4'h0, irq_mask};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_mux};
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Count sources
    logic div_tick;
    logic [3:0] pin_level;
    logic [3:0] pin_fall;

    tick_divider #(.DIV(`TICK_DIV)) u_div ( // R1
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(div_tick)
    );

    pin_sync #(.WIDTH(4)) u_sync ( // R3
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin({gate_one_pin, gate_zero_pin, timer_one_count_pin, timer_zero_count_pin}),
        .level(pin_level),
        .fall(pin_fall)
    );

    logic [1:0] mode0;
    logic [1:0] mode1;
    logic split0;
    logic src_tick0;
    logic src_tick1;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc0_high;
    logic [16:0] nxt0;
    logic [16:0] nxt1;
    logic ovf0_evt;
    logic ovf1_evt;

    assign mode0 = timer_mode_select[`MODE0_HI:`MODE0_LO]; // R10
    assign mode1 = timer_mode_select[`MODE1_HI:`MODE1_LO];
    assign split0 = timer_pkg::mode_e'(mode0) == timer_pkg::MODE_SPLIT; // R17
    assign src_tick0 = timer_mode_select[`SRC0_BIT] ? pin_fall[0] : div_tick; // R9 R2
    assign src_tick1 = timer_mode_select[`SRC1_BIT] ? pin_fall[1] : div_tick; // R9 R2
    assign run0 = timer_ctrl_flags[`RUN0_BIT] && (!timer_mode_select[`GATE_EN0_BIT] || pin_level[2]); // R6 R8
    assign run1 = timer_ctrl_flags[`RUN1_BIT] && (!timer_mode_select[`GATE_EN1_BIT] || pin_level[3]); // R6 R8
    assign inc0 = run0 && src_tick0;
    // Timer 1 stands still in split mode of its own
    assign inc1 = run1 && src_tick1 && timer_pkg::mode_e'(mode1) != timer_pkg::MODE_SPLIT;
    // Split high byte is a plain timer run by timer 1's run bit
    assign inc0_high = split0 && timer_ctrl_flags[`RUN1_BIT] && div_tick; // R15
    assign nxt0 = step(mode0, timer_zero_low_byte, timer_zero_high_byte);
    assign nxt1 = step(mode1, timer_one_low_byte, timer_one_high_byte);
    assign ovf0_evt = inc0 && nxt0[16]; // R16
    // Timer 1 loses its flag while timer 0 is split
    assign ovf1_evt = split0 ? (inc0_high && timer_zero_high_byte == 8'hff) : (inc1 && nxt1[16]); // R15 R16

    // Software write of a byte wins over counting that cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_zero_low_byte <= `COUNT_RST;
        end else if (wr_t0l) begin
            timer_zero_low_byte <= w_byte; // R13
        end else if (inc0 && !wr_t0h) begin
            timer_zero_low_byte <= nxt0[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_zero_high_byte <= `COUNT_RST;
        end else if (wr_t0h) begin
            timer_zero_high_byte <= w_byte; // R13
        end else if (inc0_high) begin
            timer_zero_high_byte <= timer_zero_high_byte + 8'h01; // R15
        end else if (inc0 && !split0 && !wr_t0l) begin
            timer_zero_high_byte <= nxt0[15:8];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_one_low_byte <= `COUNT_RST;
        end else if (wr_t1l) begin
            timer_one_low_byte <= w_byte; // R13
        end else if (inc1 && !wr_t1h) begin
            timer_one_low_byte <= nxt1[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_one_high_byte <= `COUNT_RST;
        end else if (wr_t1h) begin
            timer_one_high_byte <= w_byte; // R13
        end else if (inc1 && !wr_t1l) begin
            timer_one_high_byte <= nxt1[15:8];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_mode_select <= `MODE_SEL_RST;
        end else if (wr_mode) begin
            timer_mode_select <= w_byte; // R10
        end
    end

    // Hardware set wins over interrupt-entry clear and software write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_ctrl_flags <= `CTRL_FLAGS_RST; // R4
        end else begin
            if (wr_ctrl) begin
                timer_ctrl_flags[`RUN1_BIT] <= w_byte[`RUN1_BIT]; // R6
                timer_ctrl_flags[`RUN0_BIT] <= w_byte[`RUN0_BIT];
            end
            if (ovf0_evt) begin
                timer_ctrl_flags[`OVF0_BIT] <= 1'b1; // R16
            end else if (isr_enter_timer_zero) begin
                timer_ctrl_flags[`OVF0_BIT] <= 1'b0; // R5
            end
            if (ovf1_evt) begin
                timer_ctrl_flags[`OVF1_BIT] <= 1'b1; // R16
            end else if (isr_enter_timer_one) begin
                timer_ctrl_flags[`OVF1_BIT] <= 1'b0; // R5
            end
            if (pin_fall[2]) begin
                timer_ctrl_flags[`PIN0F_BIT] <= 1'b1;
            end else if (isr_enter_pin_zero) begin
                timer_ctrl_flags[`PIN0F_BIT] <= 1'b0; // R7
            end else if (wr_ctrl) begin
                timer_ctrl_flags[`PIN0F_BIT] <= w_byte[`PIN0F_BIT]; // R7
            end
            if (pin_fall[3]) begin
                timer_ctrl_flags[`PIN1F_BIT] <= 1'b1;
            end else if (isr_enter_pin_one) begin
                timer_ctrl_flags[`PIN1F_BIT] <= 1'b0; // R7
            end else if (wr_ctrl) begin
                timer_ctrl_flags[`PIN1F_BIT] <= w_byte[`PIN1F_BIT]; // R7
            end
        end
    end

    // Interrupt status: sticky, write one to clear, set wins
    logic [3:0] events;

    assign events = {pin_fall[3], pin_fall[2], ovf1_evt, ovf0_evt};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 4'h0;
        end else begin
            irq_status <= (irq_status & ~(wr_stat ? w_byte[3:0] : 4'h0)) | events;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `IRQ_MASK_RST;
        end else if (wr_mask) begin
            irq_mask <= w_byte[3:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule : dual_timer_counter

// ==== tb/timer_properties.sv ====
`timescale 1ns/1ps

module timer_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic mapped(input logic [11:0] a);
        return a inside {12'h220, 12'h224, 12'h228, 12'h22c, 12'h230, 12'h234, 12'h240, 12'h244};
    endfunction : mapped

    a_bresp_held:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_write_answer:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_rdata_held:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before accepted");
    a_read_refused:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_upper_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_ctrl_unused_zero:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h220
            |=> s_axi_rdata[2] == 1'b0 && s_axi_rdata[0] == 1'b0)
        else $error("unused control bits read as one");
    a_unmapped_read:
        assert property (s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr)
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_read:
        assert property (s_axi_arvalid && s_axi_arready && mapped(s_axi_araddr) |=> s_axi_rresp == 2'h0)
        else $error("mapped read refused");
endmodule : timer_properties

// ==== tb/pin_model.sv ====
`timescale 1ns/1ps

module pin_model (
    // Clock
    input wire logic ref_clk,
    // Far-side pins, idle high
    output logic count_zero,
    output logic count_one,
    output logic gate_zero,
    output logic gate_one
);
    initial begin
        count_zero = 1'b1;
        count_one = 1'b1;
        gate_zero = 1'b1;
        gate_one = 1'b1;
    end

    // Two cycles per level so no edge is lost in the synchroniser
    task automatic pulse(input logic sel, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge ref_clk);
            if (sel)
                count_one <= ~count_one;
            else
                count_zero <= ~count_zero;
            @(posedge ref_clk);
        end
    endtask : pulse

    task automatic set_gate(input logic sel, input logic level);
        @(posedge ref_clk);
        if (sel)
            gate_one <= level;
        else
            gate_zero <= level;
    endtask : set_gate
endmodule : pin_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`include "timer_regs.svh"

module tb;
    localparam logic [11:0] A_CTRL = {`CTRL_FLAGS_IDX, 2'b00};
    localparam logic [11:0] A_MODE = {`MODE_SEL_IDX, 2'b00};
    localparam logic [11:0] A_T0L = {`LOW0_IDX, 2'b00};
    localparam logic [11:0] A_T1L = {`LOW1_IDX, 2'b00};
    localparam logic [11:0] A_T0H = {`HIGH0_IDX, 2'b00};
    localparam logic [11:0] A_T1H = {`HIGH1_IDX, 2'b00};
    localparam logic [11:0] A_STAT = {`IRQ_STATUS_IDX, 2'b00};
    localparam logic [11:0] A_MASK = {`IRQ_MASK_IDX, 2'b00};

    logic ref_clk, rst_n, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic c0, c1, g0, g1;
    logic [3:0] isr_vec;
    logic [55:0] cases [6];
    logic [7:0] t, m, lo, hi, elo, ehi, fl;
    int errors = 0;
    int tests_run = 0;

    dual_timer_counter DUT (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer_zero_count_pin(c0), .timer_one_count_pin(c1),
        .gate_zero_pin(g0), .gate_one_pin(g1), .isr_enter_timer_zero(isr_vec[0]),
        .isr_enter_timer_one(isr_vec[1]), .isr_enter_pin_zero(isr_vec[2]),
        .isr_enter_pin_one(isr_vec[3]), .irq(irq)
    );

    pin_model pins (.ref_clk(ref_clk), .count_zero(c0), .count_one(c1), .gate_zero(g0), .gate_one(g1));

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd

    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask : rc

    task automatic isr(input int k);
        @(posedge ref_clk);
        isr_vec[k] <= 1'b1;
        @(posedge ref_clk);
        isr_vec[k] <= 1'b0;
    endtask : isr

    task automatic summarize();
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        summarize();
    end

    initial begin
        // Timer, mode, low, high, expected low, expected high, flag; one pin fall each
        cases = '{56'h00_00_1f_00_00_01_00, 56'h00_00_ff_ff_e0_00_01, 56'h00_01_ff_12_00_13_00,
                  56'h00_02_ff_40_40_40_01, 56'h00_03_ff_55_00_55_01, 56'h01_01_ff_ff_00_00_01};
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        isr_vec = '0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rc(A_CTRL, 32'h0);
        wr(A_MODE, 8'hff);
        rc(A_MODE, 32'hff);
        wr(A_CTRL, 8'ha0);
        rc(A_CTRL, 32'h0);
        wr(A_CTRL, 8'h0a);
        rc(A_CTRL, 32'h0a);
        isr(2);
        rc(A_CTRL, 32'h08);
        // Ten ticks in 120 clocks, one either way for bus latency
        wr(A_MODE, 8'h01);
        wr(A_T0L, 8'h00);
        wr(A_CTRL, 8'h10);
        repeat (120) @(posedge ref_clk);
        wr(A_CTRL, 8'h00);
        rd(A_T0L, d);
        check({31'h0, d >= 32'd9 && d <= 32'd11}, 32'h1);
        repeat (40) @(posedge ref_clk);
        rc(A_T0L, d);
        for (int i = 0; i < 6; i++) begin
            {t, m, lo, hi, elo, ehi, fl} = cases[i];
            wr(A_MODE, 8'(({6'h01, m[1:0]}) << (4 * t[0])));
            wr(t[0] ? A_T1L : A_T0L, lo);
            wr(t[0] ? A_T1H : A_T0H, hi);
            wr(A_CTRL, t[0] ? 8'h40 : 8'h10);
            pins.pulse(t[0], 1);
            repeat (4) @(posedge ref_clk);
            wr(A_CTRL, 8'h00);
            rc(t[0] ? A_T1L : A_T0L, {24'h0, elo});
            rc(t[0] ? A_T1H : A_T0H, {24'h0, ehi});
            rc(A_CTRL, 32'(fl) << (t[0] ? 7 : 5));
            isr(t[0]);
            rc(A_CTRL, 32'h0);
        end
        // Split high byte runs on timer 1's run bit and overflows into its flag
        wr(A_MODE, 8'h03);
        wr(A_T0H, 8'hff);
        wr(A_CTRL, 8'h40);
        repeat (30) @(posedge ref_clk);
        wr(A_CTRL, 8'h00);
        rc(A_CTRL, 32'h80);
        isr(1);
        // Gated counter: gate low blocks pulses, and its fall raises the pin flag
        wr(A_MODE, 8'h0d);
        wr(A_T0L, 8'h00);
        pins.set_gate(1'b0, 1'b0);
        wr(A_CTRL, 8'h10);
        pins.pulse(1'b0, 2);
        pins.set_gate(1'b0, 1'b1);
        pins.pulse(1'b0, 3);
        repeat (4) @(posedge ref_clk);
        rc(A_CTRL, 32'h12);
        wr(A_CTRL, 8'h02);
        rc(A_T0L, 32'h3);
        isr(2);
        rc(A_CTRL, 32'h0);
        rc(A_STAT, 32'h7);
        check({31'h0, irq}, 32'h0);
        wr(A_MASK, 8'h04);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h1);
        wr(A_STAT, 8'h04);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        rc(A_STAT, 32'h3);
        wr(12'h300, 8'h55);
        check({30'h0, resp}, 32'h2);
        rd(12'h300, d);
        check({30'h0, resp}, 32'h2);
        summarize();
    end
endmodule : tb

bind dual_timer_counter timer_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
